// [core/mai_exec.sv]
// Execute stage for the data-move and indirect-addressing instructions.
`timescale 1ns/100ps

// Notes on behaviour
// - indirect moves use pointer zero or one
// - mode 00 preinc, 01 predec, 10/11 post
// - address is pointer plus one, minus one, offset
// - pointer steps by one; relative form holds
// - indirect register redirects to pointed location
// - pointer is 16 bits and wraps
// - bank literal load, flags untouched
// - 7-bit program latch literal load, flags untouched
// - 8-bit accumulator literal load, flags untouched
// - accumulator copied to file register
// - pointer stepping never touches flags
module mai_exec (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Instruction from decode.
  input wire logic instr_valid,
  input wire logic [mai_pkg::INSTR_W-1:0] instr_word,
  // Data memory.
  input wire logic [mai_pkg::DATA_W-1:0] mem_rdata,
  output logic [mai_pkg::ADDR_W-1:0] mem_addr,
  output logic [mai_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  // File register write port.
  output logic [mai_pkg::FILE_W-1:0] file_addr,
  output logic [mai_pkg::DATA_W-1:0] file_wdata,
  output logic file_we,
  // Core state.
  output logic [mai_pkg::DATA_W-1:0] acc,
  output logic zero_flag,
  output logic [mai_pkg::BANK_W-1:0] bank_select,
  output logic [mai_pkg::PLAT_W-1:0] prog_latch,
  output logic [mai_pkg::ADDR_W-1:0] pointer0,
  output logic [mai_pkg::ADDR_W-1:0] pointer1,
  // Completion.
  output logic instr_done,
  output logic instr_unknown
);
  import mai_pkg::*;

  function automatic logic hit(input logic [INSTR_W-1:0] w,
                               input logic [INSTR_W-1:0] m,
                               input logic [INSTR_W-1:0] v);
    hit = (w & m) == v;
  endfunction : hit

  function automatic mai_op_t decode(input logic [INSTR_W-1:0] w);
    mai_op_t r;
    r = MAI_NONE;
    if (hit(w, MSK_IND, OPC_IND_RD)) r = MAI_IND_RD;
    else if (hit(w, MSK_IND, OPC_IND_WR)) r = MAI_IND_WR;
    else if (hit(w, MSK_REL, OPC_REL_RD)) r = MAI_REL_RD;
    else if (hit(w, MSK_REL, OPC_REL_WR)) r = MAI_REL_WR;
    else if (hit(w, MSK_BANK, OPC_BANK)) r = MAI_BANK;
    else if (hit(w, MSK_PLAT, OPC_PLAT)) r = MAI_PLAT;
    else if (hit(w, MSK_LACC, OPC_LACC)) r = MAI_LACC;
    else if (hit(w, MSK_STORE, OPC_STORE)) r = MAI_STORE;
    decode = r;
  endfunction : decode

  logic [ADDR_W-1:0] ptr0_reg, ptr1_reg, mem_addr_reg;
  logic [DATA_W-1:0] acc_reg, mem_wdata_reg, file_wdata_reg;
  logic [FILE_W-1:0] file_addr_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [PLAT_W-1:0] plat_reg;
  logic zero_reg, mem_we_reg, mem_re_reg, file_we_reg;
  logic rd_pending_reg, done_reg, unknown_reg;

  mai_op_t op;
  logic is_ind, is_rel, sel, redirect;
  logic [MODE_W-1:0] mm;
  logic [FILE_W-1:0] fa;
  logic [ADDR_W-1:0] ptr_cur, ofs_ext, eff_addr, ptr_next;
  logic [DATA_W-1:0] acc_now;

  always_comb begin
    op = instr_valid ? decode(instr_word) : MAI_NONE;
    is_ind = (op == MAI_IND_RD) || (op == MAI_IND_WR);
    is_rel = (op == MAI_REL_RD) || (op == MAI_REL_WR);
    mm = instr_word[MODE_W-1:0];
    fa = instr_word[FILE_W-1:0];
    redirect = (op == MAI_STORE) && (fa == F_IND0 || fa == F_IND1);
    // Pointer number sits in a different bit for the relative form.
    if (is_rel) sel = instr_word[REL_N_BIT];
    else if (redirect) sel = (fa == F_IND1);
    else sel = instr_word[MM_N_BIT];
    ptr_cur = sel ? ptr1_reg : ptr0_reg;
    ofs_ext = {{(ADDR_W-OFS_W){instr_word[OFS_W-1]}},
               instr_word[OFS_W-1:0]};
    // Sums stay at 16 bits so stepping wraps at both ends.
    if (is_rel) eff_addr = ptr_cur + ofs_ext;
    else if (is_ind && mm == MM_PREINC) eff_addr = ptr_cur + PTR_ONE;
    else if (is_ind && mm == MM_PREDEC) eff_addr = ptr_cur - PTR_ONE;
    else eff_addr = ptr_cur;
    if (mm[MM_DEC_BIT]) ptr_next = ptr_cur - PTR_ONE;
    else ptr_next = ptr_cur + PTR_ONE;
    // A read still landing this cycle is forwarded to the accumulator use.
    acc_now = rd_pending_reg ? mem_rdata : acc_reg;
  end

  // Pointer registers: stepped by indirect modes, loaded by byte stores.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr0_reg <= PTR_RST;
      ptr1_reg <= PTR_RST;
    end else if (is_ind) begin
      if (sel) ptr1_reg <= ptr_next;
      else ptr0_reg <= ptr_next;
    end else if (op == MAI_STORE) begin
      if (fa == F_PTR0_LO) ptr0_reg[DATA_W-1:0] <= acc_now;
      if (fa == F_PTR0_HI) ptr0_reg[ADDR_W-1:DATA_W] <= acc_now;
      if (fa == F_PTR1_LO) ptr1_reg[DATA_W-1:0] <= acc_now;
      if (fa == F_PTR1_HI) ptr1_reg[ADDR_W-1:DATA_W] <= acc_now;
    end
  end

  // Data memory access, one request per indirect instruction.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_reg <= PTR_RST;
      mem_wdata_reg <= DATA_RST;
      mem_we_reg <= 1'b0;
      mem_re_reg <= 1'b0;
      rd_pending_reg <= 1'b0;
    end else begin
      mem_we_reg <= (op == MAI_IND_WR) || (op == MAI_REL_WR) || redirect;
      mem_re_reg <= (op == MAI_IND_RD) || (op == MAI_REL_RD);
      rd_pending_reg <= (op == MAI_IND_RD) || (op == MAI_REL_RD);
      if (is_ind || is_rel || redirect) begin
        mem_addr_reg <= eff_addr;
        mem_wdata_reg <= acc_now;
      end
    end
  end

  // File register writes for ordinary addresses.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      file_addr_reg <= FILE_RST;
      file_wdata_reg <= DATA_RST;
      file_we_reg <= 1'b0;
    end else begin
      file_we_reg <= (op == MAI_STORE) && !redirect &&
                     !(fa == F_PTR0_LO || fa == F_PTR0_HI ||
                       fa == F_PTR1_LO || fa == F_PTR1_HI);
      if (op == MAI_STORE) begin
        file_addr_reg <= fa;
        file_wdata_reg <= acc_now;
      end
    end
  end

  // Accumulator and zero flag; a literal load wins over a landing read.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= DATA_RST;
      zero_reg <= 1'b0;
    end else if (op == MAI_LACC) begin
      acc_reg <= instr_word[DATA_W-1:0];
    end else if (rd_pending_reg) begin
      acc_reg <= mem_rdata;
      zero_reg <= (mem_rdata == DATA_RST);
    end
  end

  // Bank select and program latch.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg <= BANK_RST;
      plat_reg <= PLAT_RST;
    end else begin
      if (op == MAI_BANK) bank_reg <= instr_word[BANK_W-1:0];
      if (op == MAI_PLAT) plat_reg <= instr_word[PLAT_W-1:0];
    end
  end

  // Completion flags: every accepted word finishes in one cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      unknown_reg <= 1'b0;
    end else begin
      done_reg <= instr_valid && (op != MAI_NONE);
      unknown_reg <= instr_valid && (op == MAI_NONE);
    end
  end

  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_we = mem_we_reg;
  assign mem_re = mem_re_reg;
  assign file_addr = file_addr_reg;
  assign file_wdata = file_wdata_reg;
  assign file_we = file_we_reg;
  assign acc = acc_reg;
  assign zero_flag = zero_reg;
  assign bank_select = bank_reg;
  assign prog_latch = plat_reg;
  assign pointer0 = ptr0_reg;
  assign pointer1 = ptr1_reg;
  assign instr_done = done_reg;
  assign instr_unknown = unknown_reg;

  a_ptr_select: assert property (@(posedge clock) disable iff (!rst_n)
    is_ind && sel |=> $stable(ptr0_reg))
    else $error("pointer zero moved on a pointer one access");
  a_preinc_addr: assert property (@(posedge clock) disable iff (!rst_n)
    is_ind && mm == MM_PREINC && !sel |=>
    mem_addr_reg == $past(ptr0_reg) + PTR_ONE)
    else $error("preincrement address wrong");
  a_postdec_addr: assert property (@(posedge clock) disable iff (!rst_n)
    is_ind && mm == MM_POSTDEC && sel |=>
    mem_addr_reg == $past(ptr1_reg) && ptr1_reg == mem_addr_reg - PTR_ONE)
    else $error("postdecrement address or update wrong");
  a_rel_hold: assert property (@(posedge clock) disable iff (!rst_n)
    is_rel |=> $stable(ptr0_reg) && $stable(ptr1_reg))
    else $error("relative form changed a pointer");
  a_ind_redirect: assert property (@(posedge clock) disable iff (!rst_n)
    redirect |=> mem_we_reg && !file_we_reg)
    else $error("indirect register store not redirected");
  a_ptr_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    is_ind && !sel && !mm[MM_DEC_BIT] && ptr0_reg == ~PTR_RST |=>
    ptr0_reg == PTR_RST)
    else $error("pointer did not wrap");
  a_bank_load: assert property (@(posedge clock) disable iff (!rst_n)
    op == MAI_BANK && !rd_pending_reg |=>
    bank_reg == $past(instr_word[BANK_W-1:0]) && $stable(zero_reg))
    else $error("bank literal load wrong");
  a_plat_load: assert property (@(posedge clock) disable iff (!rst_n)
    op == MAI_PLAT |=> plat_reg == $past(instr_word[PLAT_W-1:0]))
    else $error("program latch load wrong");
  a_acc_load: assert property (@(posedge clock) disable iff (!rst_n)
    op == MAI_LACC |=> acc_reg == $past(instr_word[DATA_W-1:0]) &&
    $stable(zero_reg))
    else $error("accumulator literal load wrong");
  a_store_file: assert property (@(posedge clock) disable iff (!rst_n)
    op == MAI_STORE && fa > F_PTR1_HI && !rd_pending_reg |=>
    file_we_reg && file_wdata_reg == acc_reg && $stable(acc_reg))
    else $error("accumulator store wrong");
  a_step_flags: assert property (@(posedge clock) disable iff (!rst_n)
    op == MAI_IND_WR && !rd_pending_reg |=> $stable(zero_reg))
    else $error("pointer step changed the zero flag");
  a_read_zero: assert property (@(posedge clock) disable iff (!rst_n)
    rd_pending_reg && op != MAI_LACC |=> zero_reg == (acc_reg == DATA_RST))
    else $error("zero flag disagrees with moved byte");
  a_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && op != MAI_NONE |=> done_reg && !unknown_reg)
    else $error("instruction did not finish in one cycle");
endmodule : mai_exec

// [core/mai_pkg.sv]
// Constants, encodings and types for the move and indirect execute block.
package mai_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int FILE_W = 7;
  localparam int BANK_W = 5;
  localparam int PLAT_W = 7;
  localparam int OFS_W = 6;
  localparam int MODE_W = 2;

  // Operand field positions inside the instruction word.
  localparam int MM_N_BIT = 2;
  localparam int REL_N_BIT = 6;
  localparam int MM_DEC_BIT = 0;

  // Pointer mode field encodings.
  localparam logic [MODE_W-1:0] MM_PREINC = 2'h0;
  localparam logic [MODE_W-1:0] MM_PREDEC = 2'h1;
  localparam logic [MODE_W-1:0] MM_POSTINC = 2'h2;
  localparam logic [MODE_W-1:0] MM_POSTDEC = 2'h3;

  // Opcode masks and match values.
  localparam logic [INSTR_W-1:0] MSK_IND = 14'h3ff8;
  localparam logic [INSTR_W-1:0] OPC_IND_RD = 14'h0010;
  localparam logic [INSTR_W-1:0] OPC_IND_WR = 14'h0018;
  localparam logic [INSTR_W-1:0] MSK_REL = 14'h3f80;
  localparam logic [INSTR_W-1:0] OPC_REL_RD = 14'h3f00;
  localparam logic [INSTR_W-1:0] OPC_REL_WR = 14'h3f80;
  localparam logic [INSTR_W-1:0] MSK_BANK = 14'h3fe0;
  localparam logic [INSTR_W-1:0] OPC_BANK = 14'h0020;
  localparam logic [INSTR_W-1:0] MSK_PLAT = 14'h3f80;
  localparam logic [INSTR_W-1:0] OPC_PLAT = 14'h3180;
  localparam logic [INSTR_W-1:0] MSK_LACC = 14'h3f00;
  localparam logic [INSTR_W-1:0] OPC_LACC = 14'h3000;
  localparam logic [INSTR_W-1:0] MSK_STORE = 14'h3f80;
  localparam logic [INSTR_W-1:0] OPC_STORE = 14'h0080;

  // Core file addresses handled inside the block.
  localparam logic [FILE_W-1:0] F_IND0 = 7'h00;
  localparam logic [FILE_W-1:0] F_IND1 = 7'h01;
  localparam logic [FILE_W-1:0] F_PTR0_LO = 7'h04;
  localparam logic [FILE_W-1:0] F_PTR0_HI = 7'h05;
  localparam logic [FILE_W-1:0] F_PTR1_LO = 7'h06;
  localparam logic [FILE_W-1:0] F_PTR1_HI = 7'h07;

  // Reset values and step sizes.
  localparam logic [ADDR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] PTR_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
  localparam logic [PLAT_W-1:0] PLAT_RST = 7'h00;
  localparam logic [FILE_W-1:0] FILE_RST = 7'h00;

  typedef enum {
    MAI_NONE, MAI_IND_RD, MAI_IND_WR, MAI_REL_RD, MAI_REL_WR,
    MAI_BANK, MAI_PLAT, MAI_LACC, MAI_STORE
  } mai_op_t;
endpackage : mai_pkg

// [verification/mai_mem_model.sv]
// Behavioural data memory that answers the block's indirect accesses.
`timescale 1ns/100ps
module mai_mem_model (
  // Clock.
  input wire logic clock,
  // Memory port.
  input wire logic [mai_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [mai_pkg::DATA_W-1:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [mai_pkg::DATA_W-1:0] mem_rdata
);
  import mai_pkg::*;
  logic [DATA_W-1:0] mem_reg [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_reg[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
    end
  end

  // Outside a read the lines show the inverse, so a stale byte never matches.
  assign mem_rdata = mem_re ? mem_reg[mem_addr] : ~mem_reg[mem_addr];

  always @(posedge clock) begin
    if (mem_we) begin
      mem_reg[mem_addr] <= mem_wdata;
    end
  end
endmodule : mai_mem_model

// [verification/tb.sv]
// Self-checking testbench for the move and indirect execute block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  import mai_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [INSTR_W-1:0] instr_word = 14'h0000;
  logic [DATA_W-1:0] mem_rdata, mem_wdata, file_wdata, acc;
  logic [ADDR_W-1:0] mem_addr, pointer0, pointer1, ea, np;
  logic mem_we, mem_re, file_we, zero_flag, instr_done, instr_unknown, z;
  logic [FILE_W-1:0] file_addr;
  logic [BANK_W-1:0] bank_select;
  logic [PLAT_W-1:0] prog_latch;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;

  always #25 clock = ~clock;

  mai_exec dut_u (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
    .acc(acc), .zero_flag(zero_flag), .bank_select(bank_select),
    .prog_latch(prog_latch), .pointer0(pointer0), .pointer1(pointer1),
    .instr_done(instr_done), .instr_unknown(instr_unknown));

  mai_mem_model mem_u (.clock(clock), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_rdata(mem_rdata));

  function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : pat

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Presents one word and returns settled in the answer cycle.
  task automatic run(input logic [INSTR_W-1:0] w);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
  endtask : run

  task automatic settle();
    @(posedge clock);
    #1;
  endtask : settle

  task automatic set_ptr(input logic n, input logic [ADDR_W-1:0] v);
    run(OPC_LACC | {6'h00, v[7:0]});
    run(OPC_STORE | {7'h00, (n ? F_PTR1_LO : F_PTR0_LO)});
    run(OPC_LACC | {6'h00, v[15:8]});
    run(OPC_STORE | {7'h00, (n ? F_PTR1_HI : F_PTR0_HI)});
  endtask : set_ptr

  task automatic t_modes();
    for (int wr = 0; wr < 2; wr++) begin
      for (int n = 0; n < 2; n++) begin
        for (int m = 0; m < 4; m++) begin
          set_ptr(n[0], 16'h1234);
          ea = (m == 0) ? 16'h1235 : (m == 1) ? 16'h1233 : 16'h1234;
          np = m[0] ? 16'h1233 : 16'h1235;
          z = zero_flag;
          run((wr ? OPC_IND_WR : OPC_IND_RD) | {11'h000, n[0], m[1:0]});
          `CHK("done", 1'b1, instr_done)
          `CHK("addr", ea, mem_addr)
          `CHK("ptr", np, n ? pointer1 : pointer0)
          `CHK("strobe", 1'b1, wr ? mem_we : mem_re)
          if (wr) begin
            `CHK("wdata", 8'h12, mem_wdata)
            `CHK("zero", z, zero_flag)
          end else begin
            settle();
            `CHK("acc", pat(ea), acc)
            `CHK("zero", 1'b0, zero_flag)
          end
        end
      end
    end
  endtask : t_modes

  task automatic t_wrap();
    set_ptr(1'b0, 16'hffff);
    run(OPC_IND_RD);
    `CHK("wrap addr", 16'h0000, mem_addr)
    `CHK("wrap ptr", 16'h0000, pointer0)
    run(OPC_IND_RD | 14'h0003);
    `CHK("under ptr", 16'hffff, pointer0)
    set_ptr(1'b1, 16'h0059);
    run(OPC_IND_RD | 14'h0004);
    settle();
    `CHK("zero byte", 1'b1, zero_flag)
  endtask : t_wrap

  task automatic t_literals();
    run(OPC_BANK | 14'h000f);
    `CHK("bank", 5'h0f, bank_select)
    run(OPC_PLAT | 14'h007f);
    `CHK("latch", 7'h7f, prog_latch)
    run(OPC_LACC | 14'h00ff);
    `CHK("lacc", 8'hff, acc)
    `CHK("flags", 1'b1, zero_flag)
    run(OPC_STORE | 14'h002a);
    `CHK("fwe", 1'b1, file_we)
    `CHK("faddr", 7'h2a, file_addr)
    `CHK("fdata", 8'hff, file_wdata)
    `CHK("acc kept", 8'hff, acc)
    np = pointer0;
    run(OPC_STORE | {7'h00, F_IND0});
    `CHK("ind we", 2'b10, {mem_we, file_we})
    `CHK("ind addr", np, mem_addr)
    run(OPC_IND_WR | 14'h0002);
    `CHK("wr keeps z", 1'b1, zero_flag)
    `CHK("wr wrap", 16'h0000, pointer0)
    run(14'h0000);
    `CHK("refused", 2'b01, {instr_done, instr_unknown})
  endtask : t_literals

  task automatic t_relative();
    set_ptr(1'b1, 16'h2000);
    run(OPC_REL_RD | 14'h0060);
    `CHK("rel neg", 16'h1fe0, mem_addr)
    `CHK("rel ptr", 16'h2000, pointer1)
    run(OPC_REL_RD | 14'h005f);
    `CHK("rel pos", 16'h201f, mem_addr)
    run(OPC_LACC | 14'h00c3);
    run(OPC_REL_WR | 14'h0045);
    `CHK("rel wr", 16'h2005, mem_addr)
    run(OPC_REL_RD | 14'h0045);
    settle();
    `CHK("rel back", 8'hc3, acc)
    `CHK("rel ptr2", 16'h2000, pointer1)
  endtask : t_relative

  // Back-to-back words: a landing read feeds the next write, and a literal
  // load right after a read wins the accumulator and leaves zero alone.
  task automatic t_b2b();
    set_ptr(1'b0, 16'h0058);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= OPC_IND_RD | 14'h0002;
    @(posedge clock);
    instr_word <= OPC_IND_WR | 14'h0002;
    @(posedge clock);
    instr_word <= OPC_IND_RD | 14'h0002;
    @(posedge clock);
    instr_word <= OPC_LACC | 14'h005a;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    `CHK("fwd data", pat(16'h0058), mem_wdata)
    `CHK("b2b ptr", 16'h005b, pointer0)
    `CHK("b2b addr", 16'h005a, mem_addr)
    `CHK("lit wins", 8'h5a, acc)
    `CHK("lit zero", 1'b0, zero_flag)
    `CHK("b2b done", 1'b1, instr_done)
  endtask : t_b2b

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    `CHK("rst", 25'h000_0000, {pointer0, acc, zero_flag})
    t_modes();
    t_wrap();
    t_literals();
    t_relative();
    t_b2b();
    give_verdict();
  end
endmodule : tb
